// file: monitor_host_model.sv
// Partner: power monitor, host and slow lock/load responders
`timescale 1ns/1ns
module monitor_host_model (
   // Clock and flag seen
   input wire logic clk,
   input wire logic flag_oe,
   // Pins driven
   output logic chip_reset,
   output logic park_low,
   output logic power_req,
   output logic pll_locked,
   output logic load_done
);
   logic [7:0] cnt = 8'h00;
   initial begin
      chip_reset = 1'b0;
      park_low = 1'b0;
      power_req = 1'b0;
   end
   // Lock and load answer slowly once the flag drives
   always @(posedge clk) begin
      cnt <= #5 flag_oe ? cnt + 8'h01 : 8'h00;
      pll_locked <= #5 (cnt >= 8'h06);
      load_done <= #5 (cnt >= 8'h0E);
   end
   // Supplies settle, warning high, then release; host holds request
   task automatic power_up();
      repeat (20) @(posedge clk);
      #5 park_low = 1'b1;
      power_req = 1'b1;
      @(posedge clk);
      #5 chip_reset = 1'b1;
   endtask
   // Drop or raise a pin just after an edge
   task automatic set_pin(input int which, input logic v);
      @(posedge clk);
      #5;
      if (which == 0) chip_reset = v;
      if (which == 1) park_low = v;
      if (which == 2) power_req = v;
   endtask
endmodule // monitor_host_model

// file: reset_init_park_sequencer.sv
// Reset, auto-initialization and mirror-park sequencer
// Contract
// - Flash pins, general pins float during reset
// - Light selects, mirror reset low during reset
// - After release: lock PLL, then load flash
// - On release, enable I/Os, raise init flag
// - Init flag low when initialization completes
// - Normal park completes within 20 ms
// - After park, reset asserted, flag released
// - Warning falling edge starts fast park
// - Power request selects on or off mode (here start-up ignores it; only a low request in run starts the normal park)
`timescale 1ns/1ns
module reset_init_park_sequencer
   import rst_seq_pkg::*;
#(
   parameter int PLL_CYC = PLL_LOCK_CYC,
   parameter int LOAD_CYC = FLASH_LOAD_CYC,
   parameter int NPARK_CYC = NORMAL_PARK_CYC,
   parameter int FPARK_CYC = FAST_PARK_CYC
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // Pins from the power monitor and host
   input wire logic CHIP_RESET_IN,
   input wire logic PARK_NOW_LOW,
   input wire logic POWER_REQUEST_PIN,
   // Completion handshakes from PLL and flash loader
   input wire logic PLL_LOCKED,
   input wire logic FLASH_LOAD_DONE,
   // Flash port pins
   output flash_pins_s FLASH_PINS,
   // General pins output enables
   output logic [GPIO_W-1:0] GENERAL_PINS_OE,
   // Light and array controls
   output logic LIGHT_SELECT_0,
   output logic LIGHT_SELECT_1,
   output logic MIRROR_ARRAY_RESET_N,
   // Host init flag (tri-state: drive low or high while enabled)
   output logic INIT_STATE_FLAG,
   output logic INIT_STATE_FLAG_OE,
   // Status toward internal logic
   output logic ARRAY_DATA_EN,
   output logic PARK_DONE
);

   // Elaboration-time checks: park counts must cover the pin latency
   if (NPARK_CYC <= PIN_LAT_CYC || NPARK_CYC > NORMAL_PARK_CYC || FPARK_CYC <= PIN_LAT_CYC ||
       FPARK_CYC > FAST_PARK_CYC || PLL_CYC < 1 || LOAD_CYC < 1 || PLL_CYC >= (1 << CNT_W) ||
       LOAD_CYC >= (1 << CNT_W)) begin : g_bad_params
      $error("reset_init_park_sequencer: bad cycle parameters");
   end

   // =========================================================
   // Input synchronizers
   // =========================================================
   logic [2:0] sync1, sync2, next_sync1, next_sync2;
   logic park_dly, next_park_dly;
   logic rst_s, park_s, req_s;

   // Two-flop capture of the three pins
   always_comb begin
      next_sync1 = {CHIP_RESET_IN, PARK_NOW_LOW, POWER_REQUEST_PIN};
      next_sync2 = sync1;
      next_park_dly = sync2[1];
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         park_dly <= 1'b1;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         park_dly <= next_park_dly;
      end
   end

   assign rst_s = sync2[2];
   assign park_s = sync2[1];
   assign req_s = sync2[0];

   // Falling edge of the warning on the synchronized copy
   logic park_fall;
   assign park_fall = park_dly & ~park_s;

   // =========================================================
   // Sequencer
   // =========================================================
   seq_state_e state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;

   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n);
   endfunction

   always_comb begin
      next_state = state;
      next_cnt = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - CNT_ONE;
      if (!rst_s) begin
         next_state = ST_RESET;
         next_cnt = CNT_ZERO;
      end else if (park_fall && state != ST_RESET && state != ST_FAST_PARK && state != ST_PARKED) begin
         next_state = ST_FAST_PARK;
         // Pin latency is spent before this state, so the whole park fits the window
         next_cnt = cyc(FPARK_CYC - PIN_LAT_CYC - 1);
      end else begin
         case (state)
            ST_RESET: begin
               if (park_s) begin
                  next_state = ST_PLL_LOCK;
                  next_cnt = cyc(PLL_CYC - 1);
               end
            end
            ST_PLL_LOCK: begin
               if (PLL_LOCKED && cnt == CNT_ZERO) begin
                  next_state = ST_FLASH_LOAD;
                  next_cnt = cyc(LOAD_CYC - 1);
               end
            end
            ST_FLASH_LOAD: begin
               if (FLASH_LOAD_DONE && cnt == CNT_ZERO) begin
                  next_state = ST_RUN;
               end
            end
            ST_RUN: begin
               if (!req_s) begin
                  next_state = ST_NORMAL_PARK;
                  // Counted from the pin edge, not from this state
                  next_cnt = cyc(NPARK_CYC - PIN_LAT_CYC - 1);
               end
            end
            ST_NORMAL_PARK: begin
               if (cnt == CNT_ZERO) begin
                  next_state = ST_PARKED;
               end
            end
            ST_FAST_PARK: begin
               if (cnt == CNT_ZERO) begin
                  next_state = ST_PARKED;
               end
            end
            ST_PARKED: begin
               next_state = ST_PARKED; // Waits for reset assertion
            end
            default: begin
               next_state = ST_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         state <= ST_RESET;
         cnt <= CNT_ZERO;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // =========================================================
   // Pin outputs, registered
   // =========================================================
   flash_pins_s next_flash;
   logic [GPIO_W-1:0] next_gpio_oe;
   logic next_ls0, next_ls1, next_marst_n, next_flag, next_flag_oe, next_data_en, next_park_done;
   logic active;

   // Outputs follow the next state so they change with it
   always_comb begin
      active = (next_state != ST_RESET);
      next_flash = '0;
      next_gpio_oe = GPIO_ZERO;
      next_ls0 = 1'b0;
      next_ls1 = 1'b0;
      next_marst_n = 1'b0;
      next_flag = 1'b0;
      next_flag_oe = 1'b0;
      next_data_en = 1'b0;
      next_park_done = 1'b0;
      if (active) begin
         // I/Os come alive once reset is released
         next_flash.clk_oe = 1'b1;
         next_flash.dout_oe = 1'b1;
         next_flash.sel0 = 1'b1;
         next_flash.sel0_oe = 1'b1;
         next_flash.sel1 = 1'b1;
         next_flash.sel1_oe = 1'b1;
         next_gpio_oe = GPIO_ONES;
         next_flag_oe = 1'b1;
         next_flag = (next_state == ST_PLL_LOCK || next_state == ST_FLASH_LOAD);
         next_flash.sel0 = (next_state != ST_FLASH_LOAD);
         next_marst_n = (next_state == ST_RUN);
         next_data_en = (next_state == ST_RUN);
         next_park_done = (next_state == ST_PARKED);
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         FLASH_PINS <= '0;
         GENERAL_PINS_OE <= GPIO_ZERO;
         LIGHT_SELECT_0 <= 1'b0;
         LIGHT_SELECT_1 <= 1'b0;
         MIRROR_ARRAY_RESET_N <= 1'b0;
         INIT_STATE_FLAG <= 1'b0;
         INIT_STATE_FLAG_OE <= 1'b0;
         ARRAY_DATA_EN <= 1'b0;
         PARK_DONE <= 1'b0;
      end else begin
         FLASH_PINS <= next_flash;
         GENERAL_PINS_OE <= next_gpio_oe;
         LIGHT_SELECT_0 <= next_ls0;
         LIGHT_SELECT_1 <= next_ls1;
         MIRROR_ARRAY_RESET_N <= next_marst_n;
         INIT_STATE_FLAG <= next_flag;
         INIT_STATE_FLAG_OE <= next_flag_oe;
         ARRAY_DATA_EN <= next_data_en;
         PARK_DONE <= next_park_done;
      end
   end

endmodule // reset_init_park_sequencer

// file: rst_seq_checker.sv
// Checker: port-level assertions for the reset/init/park sequencer
`timescale 1ns/1ns
module rst_seq_checker
   import rst_seq_pkg::*;
#(
   parameter int NPARK_CYC = 8,
   parameter int FPARK_CYC = 4
) (
   // Clock, reset and pins
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CHIP_RESET_IN,
   input wire logic PARK_NOW_LOW,
   input wire logic POWER_REQUEST_PIN,
   input wire logic PLL_LOCKED,
   input wire logic FLASH_LOAD_DONE,
   // Outputs watched
   input wire flash_pins_s FLASH_PINS,
   input wire logic [GPIO_W-1:0] GENERAL_PINS_OE,
   input wire logic LIGHT_SELECT_0,
   input wire logic LIGHT_SELECT_1,
   input wire logic MIRROR_ARRAY_RESET_N,
   input wire logic INIT_STATE_FLAG,
   input wire logic INIT_STATE_FLAG_OE,
   input wire logic ARRAY_DATA_EN,
   input wire logic PARK_DONE
);
   localparam int NP_MAX = NPARK_CYC;
   localparam int FP_MAX = FPARK_CYC;
   // ==========================================
   // Assertions
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   property p_float; !CHIP_RESET_IN [*4] |-> GENERAL_PINS_OE == GPIO_ZERO && FLASH_PINS == 8'h00; endproperty
   a_float: assert property (p_float) else $error("pins driven in reset");
   property p_low; !CHIP_RESET_IN [*4] |-> !LIGHT_SELECT_0 && !LIGHT_SELECT_1 && !MIRROR_ARRAY_RESET_N; endproperty
   a_low: assert property (p_low) else $error("controls not low in reset");
   property p_order; $fell(FLASH_PINS.sel0) && FLASH_PINS.sel0_oe |-> INIT_STATE_FLAG && $past(PLL_LOCKED); endproperty
   a_order: assert property (p_order) else $error("flash load before lock");
   property p_flag; $rose(CHIP_RESET_IN) && PARK_NOW_LOW ##1 (CHIP_RESET_IN && PARK_NOW_LOW) [*3]
      |-> INIT_STATE_FLAG && INIT_STATE_FLAG_OE; endproperty
   a_flag: assert property (p_flag) else $error("init flag not raised");
   property p_done; $fell(INIT_STATE_FLAG) && INIT_STATE_FLAG_OE && $past(PARK_NOW_LOW, 3)
      |-> MIRROR_ARRAY_RESET_N && ARRAY_DATA_EN && $past(FLASH_LOAD_DONE); endproperty
   a_done: assert property (p_done) else $error("flag low before init done");
   property p_npark; $fell(POWER_REQUEST_PIN) && ARRAY_DATA_EN && CHIP_RESET_IN |-> ##[1:NP_MAX] PARK_DONE; endproperty
   a_npark: assert property (p_npark) else $error("normal park late");
   property p_rel; PARK_DONE && $fell(CHIP_RESET_IN) ##1 !CHIP_RESET_IN [*3] |-> !INIT_STATE_FLAG_OE; endproperty
   a_rel: assert property (p_rel) else $error("flag not released");
   property p_fpark; $fell(PARK_NOW_LOW) && ARRAY_DATA_EN && CHIP_RESET_IN |-> ##[1:FP_MAX] PARK_DONE; endproperty
   a_fpark: assert property (p_fpark) else $error("fast park late");
   property p_mode; ARRAY_DATA_EN |-> $past(POWER_REQUEST_PIN, 4); endproperty
   a_mode: assert property (p_mode) else $error("data on while off");
   property p_sync; $rose(CHIP_RESET_IN) && !INIT_STATE_FLAG_OE |=> !INIT_STATE_FLAG_OE; endproperty
   a_sync: assert property (p_sync) else $error("release not synchronized");
endmodule // rst_seq_checker
bind reset_init_park_sequencer rst_seq_checker #(.NPARK_CYC(NPARK_CYC), .FPARK_CYC(FPARK_CYC)) chk_i (
   .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CHIP_RESET_IN(CHIP_RESET_IN), .PARK_NOW_LOW(PARK_NOW_LOW),
   .POWER_REQUEST_PIN(POWER_REQUEST_PIN), .PLL_LOCKED(PLL_LOCKED), .FLASH_LOAD_DONE(FLASH_LOAD_DONE),
   .FLASH_PINS(FLASH_PINS), .GENERAL_PINS_OE(GENERAL_PINS_OE), .LIGHT_SELECT_0(LIGHT_SELECT_0),
   .LIGHT_SELECT_1(LIGHT_SELECT_1), .MIRROR_ARRAY_RESET_N(MIRROR_ARRAY_RESET_N), .INIT_STATE_FLAG(INIT_STATE_FLAG),
   .INIT_STATE_FLAG_OE(INIT_STATE_FLAG_OE), .ARRAY_DATA_EN(ARRAY_DATA_EN), .PARK_DONE(PARK_DONE));

// file: rst_seq_pkg.sv
// Package: constants, states and carrier structs for the reset/init/park sequencer
package rst_seq_pkg;
   // Clock rate
   localparam int CLK_HZ = 20_000_000;
   // Park timings
   localparam int NORMAL_PARK_MS = 20;
   localparam int FAST_PARK_US = 32;
   // Longest time rounds down: complete normal park within 20 ms
   localparam int NORMAL_PARK_CYC = (NORMAL_PARK_MS * (CLK_HZ / 1000));
   // Fast park must finish inside the 32 us window
   localparam int FAST_PARK_CYC = (FAST_PARK_US * (CLK_HZ / 1_000_000));
   // Pin to state-register latency: two sync flops and the state flop
   localparam int PIN_LAT_CYC = 3;
   // Default stand-in durations for PLL lock and flash load
   localparam int PLL_LOCK_CYC = 2000;
   localparam int FLASH_LOAD_CYC = 4000;
   // Width of the general pin bank [19:00]
   localparam int GPIO_W = 20;
   localparam int CNT_W = 20;
   localparam logic [CNT_W-1:0] CNT_ZERO = 20'h00000;
   localparam logic [CNT_W-1:0] CNT_ONE = 20'h00001;
   localparam logic [GPIO_W-1:0] GPIO_ZERO = 20'h00000;
   localparam logic [GPIO_W-1:0] GPIO_ONES = 20'hFFFFF;

   typedef enum logic [2:0] {
      ST_RESET,
      ST_PLL_LOCK,
      ST_FLASH_LOAD,
      ST_RUN,
      ST_NORMAL_PARK,
      ST_FAST_PARK,
      ST_PARKED
   } seq_state_e;

   // Flash port pin group: output and enable per pin
   typedef struct packed {
      logic clk;
      logic clk_oe;
      logic dout;
      logic dout_oe;
      logic sel0;
      logic sel0_oe;
      logic sel1;
      logic sel1_oe;
   } flash_pins_s;
endpackage

// file: tb_reset_init_park_sequencer.sv
// Testbench: reset, init, normal and fast park scenarios
`timescale 1ns/1ns
module tb_reset_init_park_sequencer
   import rst_seq_pkg::*;
;
   logic CLK_SYS = 1'b0;
   logic RST_N = 1'b0;
   logic cr, pk, pr, pl, ld, isf, isf_oe, lsel0, lsel1, marn, aden, pdone;
   flash_pins_s fp;
   logic [GPIO_W-1:0] goe;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;
   logic seen;
   localparam int NPARK_SIM = 8;
   localparam int FPARK_SIM = 4;
   // ==========================================
   // Clock, partner and design
   always #25 CLK_SYS = ~CLK_SYS;
   monitor_host_model pm (.clk(CLK_SYS), .flag_oe(isf_oe), .chip_reset(cr), .park_low(pk), .power_req(pr),
      .pll_locked(pl), .load_done(ld));
   reset_init_park_sequencer #(.PLL_CYC(4), .LOAD_CYC(4), .NPARK_CYC(NPARK_SIM), .FPARK_CYC(FPARK_SIM)) dut (
      .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CHIP_RESET_IN(cr), .PARK_NOW_LOW(pk), .POWER_REQUEST_PIN(pr),
      .PLL_LOCKED(pl), .FLASH_LOAD_DONE(ld), .FLASH_PINS(fp), .GENERAL_PINS_OE(goe), .LIGHT_SELECT_0(lsel0),
      .LIGHT_SELECT_1(lsel1), .MIRROR_ARRAY_RESET_N(marn), .INIT_STATE_FLAG(isf), .INIT_STATE_FLAG_OE(isf_oe),
      .ARRAY_DATA_EN(aden), .PARK_DONE(pdone));
   // ==========================================
   // Helpers
   task automatic tick();
      @(posedge CLK_SYS);
      #1;
   endtask
   task automatic chk(input string name, input logic [19:0] e, input logic [19:0] s);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, e, s);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset_pins();
      repeat (6) tick();
      chk("flash pins", 20'h00000, {12'h000, fp});
      chk("gpio oe", GPIO_ZERO, goe);
      chk("ctl low", 20'h00000, {lsel0, lsel1, marn, isf_oe});
   endtask
   task automatic t_init();
      pm.power_up();
      for (n = 0; n < 8 && isf_oe !== 1'b1; n++) tick();
      chk("flag up", 20'h00003, {isf, isf_oe});
      chk("flash pins active", 20'h0005F, {12'h000, fp});
      chk("gpio active", 20'hFFFFF, goe);
      seen = 1'b0;
      for (n = 0; n < 60 && isf !== 1'b0; n++) begin
         if (fp.sel0 === 1'b0 && pl === 1'b1) seen = 1'b1;
         tick();
      end
      chk("load after lock", 20'h00001, seen);
      chk("init length ok", 20'h00001, n >= 8);
      chk("run outputs", 20'h00007, {isf_oe, marn, aden});
   endtask
   task automatic t_park(input int which, input int lim);
      pm.set_pin(which, 1'b0);
      for (n = 0; n < lim && pdone !== 1'b1; n++) tick();
      chk("park done", 20'h00002, {pdone, aden});
      pm.set_pin(0, 1'b0);
      repeat (4) tick();
      chk("flag released", 20'h00000, isf_oe);
      chk("flash pins", 20'h00000, {12'h000, fp});
      chk("gpio oe", GPIO_ZERO, goe);
      chk("ctl low", 20'h00000, {lsel0, lsel1, marn});
   endtask
   // ==========================================
   // Main sequence and timeout
   always @(posedge CLK_SYS) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         complete_run();
      end
   end
   initial begin
      repeat (2) @(posedge CLK_SYS);
      #5 RST_N = 1'b1;
      t_reset_pins();
      t_init();
      t_park(2, NPARK_SIM);
      t_init();
      t_park(1, FPARK_SIM);
      complete_run();
   end
endmodule // tb_reset_init_park_sequencer
